// >>> eeprom_pin_ctrl.sv
// Serial EEPROM slave: pin front end, instruction decoder, array, timer.
// Assumes pins arrive asynchronous to clock and are pulled up at the pad.
`timescale 1ns/1ps
module eeprom_pin_ctrl
  import eeprom_pin_pkg::*;
#(
  parameter int AW         = 10,        // Word address width in x16 mode.
  parameter int T_WRITE    = WRITE_CYC, // Word write or erase cycles.
  parameter int T_ERALL    = ERALL_CYC, // Whole-array erase cycles.
  parameter int T_WRALL    = WRALL_CYC  // Whole-array write cycles.
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        select,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_en,
  input  wire logic        width_select,
  input  wire logic        program_permit,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int HW = AW + 3;                 // Header bits in x8 mode.
  logic [15:0]   mem [2**AW];                 // Array storage.
  logic          sel_m, sel_s, sclk_m, sclk_s, sclk_d, si_m, si_s;
  logic          ws_m, ws_s, pp_m, pp_s;      // Strap synchronisers.
  logic          sclk_rise;                   // Serial clock rising edge.
  logic          wide;                        // Word organisation is x16.
  link_state_e   state_reg;                   // Link state.
  logic [4:0]    cnt_reg;                     // Bit counter.
  logic [HW-1:0] hdr_reg;                     // Opcode and address shifter.
  logic [HW-1:0] hdr_full;                    // Header including this bit.
  logic [15:0]   dat_reg;                     // Write data shifter.
  logic [15:0]   dat_full;                    // Data including this bit.
  logic [1:0]    op_reg;                      // Opcode under execution.
  logic [AW:0]   addr_reg;                    // Byte address of operation.
  logic [1:0]    op_now;
  logic [AW:0]   addr_now;
  logic [4:0]    hdr_last, dat_last;
  logic          hdr_done, dat_done;
  logic          unlock_reg;                  // Programming unlocked.
  logic          prog_ok;                     // Programming allowed now.
  logic          prog_go;                     // Program request this cycle.
  logic [1:0]    prog_kind;                   // 0 write, 1 erase, 2 erall, 3 wrall.
  logic          busy_reg;                    // Self-timed cycle running.
  logic [31:0]   prog_cnt;                    // Remaining programming cycles.
  logic          stat_reg;                    // Ready/busy shown on output.
  logic          do_reg;                      // Read data bit.
  logic [15:0]   rd_word;                     // Word or byte under read, aligned high.
  logic [7:0]    low_cnt;                     // Deselect gap length.
  logic          sel_seen, gap_reg;           // Short-gap detection.
  logic          ack_reg;                     // Bus answer cycle.
  logic [31:0]   ctrl_reg;                    // Software control.
  logic [15:0]   done_cnt;                    // Completed programming cycles.

  // Merge data into a stored word at the given byte lane.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic w, input logic hi);
    if (w) return d;
    return hi ? {d[7:0], old[7:0]} : {old[15:8], d[7:0]};
  endfunction : merge

  // Align the selected word or byte at the top of 16 bits.
  function automatic logic [15:0] align(input logic [15:0] v, input logic w,
                                        input logic hi);
    if (w) return v;
    return {(hi ? v[15:8] : v[7:0]), 8'h00};
  endfunction : align

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin, three on the serial clock; straps reset to the pulled-up level.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {sel_m, sel_s, sclk_m, sclk_s, sclk_d, si_m, si_s} <= 7'h00;
      {ws_m, ws_s} <= {PIN_PULL, PIN_PULL};   // [RULE18]
      {pp_m, pp_s} <= {PIN_PULL, PIN_PULL};   // [RULE20]
    end else begin
      {sel_m, sel_s} <= {select, sel_m};
      {sclk_m, sclk_s, sclk_d} <= {serial_clk, sclk_m, sclk_s};
      {si_m, si_s} <= {serial_in, si_m};
      {ws_m, ws_s} <= {width_select, ws_m};
      {pp_m, pp_s} <= {program_permit, pp_m};
    end
  end

  // Only rising edges matter, so a paused clock is simply no event.
  assign sclk_rise = sel_s & sclk_s & ~sclk_d; // [RULE7] [RULE9] [RULE10]
  assign wide      = ws_s;                     // [RULE17]

  // ----------------------------------------------------------------
  // Header and data decode
  // ----------------------------------------------------------------
  // Opcode sits above the address; x8 adds one low address bit.
  always_comb begin
    hdr_full = {hdr_reg[HW-2:0], si_s};
    dat_full = {dat_reg[14:0], si_s};
    hdr_last = wide ? 5'(AW + 1) : 5'(AW + 2);
    dat_last = wide ? 5'd15 : 5'd7;           // [RULE17]
    op_now   = wide ? hdr_full[AW+1:AW] : hdr_full[AW+2:AW+1];
    addr_now = wide ? {hdr_full[AW-1:0], 1'b0} : hdr_full[AW:0];
    hdr_done = sclk_rise && state_reg == S_HDR && cnt_reg == hdr_last;  // [RULE13]
    dat_done = sclk_rise && state_reg == S_DATA && cnt_reg == dat_last; // [RULE13]
  end

  // Programming request and its kind, only when unlocked and permitted.
  always_comb begin
    prog_ok   = unlock_reg & pp_s & ~ctrl_reg[CTRL_LOCK]; // [RULE19] [RULE23]
    prog_go   = 1'b0;
    prog_kind = 2'd0;
    if (hdr_done && op_now == OP_ERASE) begin
      prog_go   = 1'b1;
      prog_kind = 2'd1;
    end else if (hdr_done && op_now == OP_EXT && addr_now[AW:AW-1] == EXT_ERALL) begin
      prog_go   = 1'b1;
      prog_kind = 2'd2;
    end else if (dat_done) begin
      prog_go   = 1'b1;
      prog_kind = (op_reg == OP_WRITE) ? 2'd0 : 2'd3;
    end
    prog_go = prog_go & prog_ok;              // [RULE19]
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  // Deselect resets the sequencer; otherwise it moves on clock rises.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_WAIT;
      cnt_reg   <= 5'd0;
      hdr_reg   <= '0;
      dat_reg   <= 16'h0000;
      op_reg    <= OP_EXT;
      addr_reg  <= '0;
    end else if (!sel_s) begin
      state_reg <= S_WAIT;                    // [RULE2] [RULE6] [RULE10]
      cnt_reg   <= 5'd0;
    end else if (sclk_rise) begin
      case (state_reg)
        // Wait for start; a busy array ignores start bits.
        S_WAIT: begin
          if (si_s && !busy_reg) begin        // [RULE21] [RULE11]
            state_reg <= S_HDR;
            cnt_reg   <= 5'd0;
            hdr_reg   <= '0;
          end
        end
        // Collect opcode and address, then dispatch.
        S_HDR: begin
          hdr_reg <= hdr_full;                // [RULE7]
          cnt_reg <= cnt_reg + 5'd1;
          if (hdr_done) begin
            cnt_reg   <= 5'd0;
            op_reg    <= op_now;
            addr_reg  <= addr_now;
            state_reg <= S_WAIT;              // [RULE14]
            if (op_now == OP_READ) begin
              state_reg <= S_READ;
            end else if (op_now == OP_WRITE ||
                         (op_now == OP_EXT && addr_now[AW:AW-1] == EXT_WRALL)) begin
              state_reg <= S_DATA;
            end
          end
        end
        // Collect write data, then return to waiting.
        S_DATA: begin
          dat_reg <= dat_full;
          cnt_reg <= cnt_reg + 5'd1;
          if (dat_done) begin
            state_reg <= S_WAIT;              // [RULE14]
          end
        end
        // Sequential read runs until deselect.
        S_READ: begin
          cnt_reg <= cnt_reg + 5'd1;
          if (cnt_reg == dat_last) begin
            cnt_reg  <= 5'd0;
            addr_reg <= addr_reg + (wide ? (AW+1)'(2) : (AW+1)'(1));
          end
        end
        default: state_reg <= S_WAIT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data output
  // ----------------------------------------------------------------
  // The addressed word or byte, moved to the top so bit 15 leaves first.
  assign rd_word = align(mem[addr_reg[AW:1]], wide, addr_reg[0]);

  // Dummy zero at dispatch, then one bit per rise, most significant first.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      do_reg <= 1'b0;
    end else if (hdr_done && op_now == OP_READ) begin
      do_reg <= 1'b0;                         // [RULE24]
    end else if (sclk_rise && state_reg == S_READ) begin
      do_reg <= rd_word[4'(15 - cnt_reg)];    // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // Lock state and array
  // ----------------------------------------------------------------
  // Power-up locked; unlock and lock work regardless of the permit pin.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unlock_reg <= 1'b0;                     // [RULE23]
    end else if (hdr_done && op_now == OP_EXT && addr_now[AW:AW-1] == EXT_UNLOCK) begin
      unlock_reg <= 1'b1;
    end else if (hdr_done && op_now == OP_EXT && addr_now[AW:AW-1] == EXT_LOCK) begin
      unlock_reg <= 1'b0;
    end
  end

  // The array takes its new contents when the self-timed cycle starts.
  always_ff @(posedge clock) begin
    if (prog_go) begin
      for (int i = 0; i < 2**AW; i++) begin
        if (prog_kind == 2'd2) begin
          mem[i] <= 16'hFFFF;
        end else if (prog_kind == 2'd3) begin
          mem[i] <= wide ? dat_full : {dat_full[7:0], dat_full[7:0]};
        end
      end
      if (prog_kind == 2'd0) begin
        mem[addr_reg[AW:1]] <= merge(mem[addr_reg[AW:1]], dat_full, wide, addr_reg[0]);
      end else if (prog_kind == 2'd1) begin
        mem[addr_now[AW:1]] <= merge(mem[addr_now[AW:1]], 16'hFFFF, wide, addr_now[0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed programming
  // ----------------------------------------------------------------
  // Runs on the system clock, blind to select and the serial clock.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      prog_cnt <= 32'h0000_0000;
      done_cnt <= 16'h0000;
    end else if (prog_go) begin
      busy_reg <= 1'b1;                       // [RULE12]
      case (prog_kind)
        2'd2:    prog_cnt <= 32'(T_ERALL - 1);
        2'd3:    prog_cnt <= 32'(T_WRALL - 1);
        default: prog_cnt <= 32'(T_WRITE - 1);
      endcase
    end else if (busy_reg) begin
      if (prog_cnt == 32'h0000_0000) begin
        busy_reg <= 1'b0;
        done_cnt <= done_cnt + 16'h0001;
      end else begin
        prog_cnt <= prog_cnt - 32'h0000_0001; // [RULE3] [RULE4]
      end
    end
  end

  // Status display: set by a started cycle, ended by deselect or start.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= 1'b0;
    end else if (prog_go) begin
      stat_reg <= 1'b1;                       // [RULE16]
    end else if (!sel_s || (sclk_rise && state_reg == S_WAIT && si_s && !busy_reg)) begin
      stat_reg <= 1'b0;
    end
  end

  // Output driven only while selected; busy reads low, ready high.
  assign serial_out    = stat_reg ? ~busy_reg : do_reg;            // [RULE22]
  assign serial_out_en = sel_s & (stat_reg | state_reg == S_READ); // [RULE1] [RULE2]

  // ----------------------------------------------------------------
  // Deselect gap monitor
  // ----------------------------------------------------------------
  // Flags a select low time shorter than the least gap; write one clears.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_cnt  <= 8'h00;
      sel_seen <= 1'b0;
      gap_reg  <= 1'b0;
    end else begin
      if (sel_s) begin
        sel_seen <= 1'b1;
        low_cnt  <= 8'h00;
      end else if (low_cnt != 8'hFF) begin
        low_cnt <= low_cnt + 8'h01;
      end
      if (sel_s && sel_seen && low_cnt != 8'h00 && low_cnt < 8'(DESELECT_GAP_CYC)) begin
        gap_reg <= 1'b1;
      end else if (avs_write && ack_reg && avs_address == REG_STATUS &&
                   avs_byteenable[0] && avs_writedata[ST_GAP]) begin
        gap_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle per access; read data captured while waitrequest is high, write data taken once it is low.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read && !ack_reg) begin
        case (avs_address)
          REG_STATUS: avs_readdata <= {22'h0, state_reg, 2'b00, sel_s, gap_reg,
                                       pp_s, wide, unlock_reg, busy_reg};
          REG_CTRL:   avs_readdata <= ctrl_reg;
          REG_COUNT:  avs_readdata <= {16'h0000, done_cnt};
          default:    avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register: bit 0 adds a software write lock.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
    end else if (avs_write && ack_reg && avs_address == REG_CTRL && avs_byteenable[0]) begin
      ctrl_reg <= {31'h0, avs_writedata[CTRL_LOCK]};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence start_seen_s;
    state_reg == S_WAIT && sclk_rise && si_s && !busy_reg;
  endsequence
  sequence read_dispatch_s;
    hdr_done && op_now == OP_READ;
  endsequence

  deselect_reset_a: assert property (!sel_s |=> state_reg == S_WAIT)  // [RULE6]
    else $error("Link left idle while deselected.");
  out_standby_a: assert property (!sel_s |-> !serial_out_en)          // [RULE2]
    else $error("Output driven while deselected.");
  start_detect_a: assert property (start_seen_s |=> state_reg == S_HDR) // [RULE21]
    else $error("Start bit not taken.");
  wait_start_a: assert property (state_reg == S_WAIT && !si_s |=> state_reg == S_WAIT) // [RULE11]
    else $error("Idle left without a start bit.");
  prog_runs_a: assert property (busy_reg && prog_cnt != 0 |=> busy_reg) // [RULE3]
    else $error("Programming ended early.");
  ready_level_a: assert property (stat_reg |-> serial_out == !busy_reg) // [RULE22]
    else $error("Ready/busy level wrong.");
  lock_blocks_a: assert property ($rose(busy_reg) |-> $past(prog_ok)) // [RULE19]
    else $error("Programming began while not permitted.");
  status_hold_a: assert property (stat_reg && sel_s && !sclk_rise |=> stat_reg) // [RULE16]
    else $error("Status display dropped without cause.");
  dummy_zero_a: assert property (read_dispatch_s |=> !serial_out && serial_out_en) // [RULE24]
    else $error("Missing zero bit before read data.");
  clock_pause_a: assert property (sel_s && !sclk_rise |=> $stable(cnt_reg)) // [RULE9]
    else $error("Bit counter moved without a clock rise.");
endmodule : eeprom_pin_ctrl

// >>> eeprom_pin_pkg.sv
// Constants, register map and state type for the serial EEPROM pin control.
// Assumes a single 40 MHz system clock; every pin is asynchronous to it.
// Function
// [RULE1] Respond to serial traffic only while selected.
// [RULE2] Select low deselects and enters standby.
// [RULE3] A started programming cycle always completes.
// [RULE4] Standby after deselect waits for programming end.
// [RULE5] Master keeps select low 250 ns between instructions.
// [RULE6] Select low holds control logic in reset.
// [RULE7] Input bits sampled on serial clock rise.
// [RULE8] Output bits change on serial clock rise.
// [RULE9] Serial clock may pause at either level.
// [RULE10] Serial clock ignored while deselected.
// [RULE11] Any clocks before start bit change nothing.
// [RULE12] Programming cycle needs no serial clock edges.
// [RULE13] Master supplies exactly the needed bit count.
// [RULE14] After last bit, wait for new start.
// [RULE15] Master deselects between instructions except sequential read.
// [RULE16] Ready/busy shown while selected until next start.
// [RULE17] Width select high is x16, low x8.
// [RULE18] Floating width select defaults to x16.
// [RULE19] Program permit low blocks all programming.
// [RULE20] Floating program permit defaults to allowed.
// [RULE21] Start bit is first rise with select, input high; the code ignores such rises while a programming cycle is busy.
// [RULE22] Busy drives output low, ready drives high.
// [RULE23] Programming locked at power-up until unlock instruction.
// [RULE24] Read sends one zero bit before data.
package eeprom_pin_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 40;    // System clock rate in MHz.
  localparam int CLK_PERIOD_NS     = 25;    // System clock period in ns.
  localparam int DESELECT_GAP_NS   = 250;   // Least deselect gap in ns.
  localparam int DESELECT_GAP_CYC  = (DESELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TIME_US     = 3000;  // Word write or erase time in us.
  localparam int ERALL_TIME_US     = 8000;  // Whole-array erase time in us.
  localparam int WRALL_TIME_US     = 16000; // Whole-array write time in us.
  localparam int WRITE_CYC         = WRITE_TIME_US * CLK_MHZ;
  localparam int ERALL_CYC         = ERALL_TIME_US * CLK_MHZ;
  localparam int WRALL_CYC         = WRALL_TIME_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_EXT     = 2'h0; // Extended group, coded in address.
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] EXT_LOCK   = 2'h0; // program_lock.
  localparam logic [1:0] EXT_WRALL  = 2'h1;
  localparam logic [1:0] EXT_ERALL  = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3; // program_unlock.
  localparam logic       PIN_PULL   = 1'h1; // Level a floating pulled-up pin reads.
  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_CTRL   = 4'h4;
  localparam logic [3:0]  REG_COUNT  = 4'h8;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_UNLOCK  = 1;
  localparam int          ST_WIDE    = 2;
  localparam int          ST_PERMIT  = 3;
  localparam int          ST_GAP     = 4;
  localparam int          ST_SEL     = 5;
  localparam int          ST_STATE   = 8;
  localparam int          CTRL_LOCK  = 0;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  // Serial link states.
  typedef enum logic [1:0] {
    S_WAIT = 2'b00,
    S_HDR  = 2'b01,
    S_DATA = 2'b10,
    S_READ = 2'b11
  } link_state_e;
endpackage : eeprom_pin_pkg

// >>> serial_eeprom_pin_control_tb.sv
// Self-checking bench for the EEPROM pin control with a serial master model.
// Assumes short programming times set through the timer parameters.
`timescale 1ns/1ps
module serial_eeprom_pin_control_tb
  import eeprom_pin_pkg::*;
;
  logic        clock, nrst, width_select, program_permit;
  logic        select, serial_clk, serial_in, serial_out, serial_out_en;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          failures = 0, compares = 0, cycles = 0;
  eeprom_pin_ctrl #(.AW(10), .T_WRITE(20), .T_ERALL(30), .T_WRALL(40)) DUT (
    .clock(clock), .nrst(nrst), .select(select), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .width_select(width_select), .program_permit(program_permit),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  serial_master master (.clock(clock), .select(select), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out));
  // Free-running 40 MHz clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Cuts a hung run short as a mismatch.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  // Compares and counts; prints only on mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // Avalon access held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_read      <= ~w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus
  // Reads a word after idle clocks, with a pause between dummy bit and data.
  task automatic rd(input logic [10:0] a, input int na, input int nd, input logic [15:0] e);
    master.sel(1'b1);
    master.shift(32'h0000_0000, 5, q);
    master.shift((32'h0000_0006 << na) | 32'(a), 3 + na, q);
    chk(q & 32'h0000_0001, 32'h0000_0000);
    repeat (40) @(posedge clock);
    master.shift(32'h0000_0000, nd, q);
    chk(q, {16'h0000, e});
    master.sel(1'b0);
  endtask : rd
  // Reset state of straps, lock and busy flag; unmapped read gives zero.
  task automatic t_reset();
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q & 32'h0000_000F, 32'h0000_000C);
    bus(1'b0, 4'hC, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
  endtask : t_reset
  // Write while locked is dropped; after unlock it runs with busy status.
  task automatic t_write();
    master.sel(1'b1);
    master.shift({3'b101, 10'h005, 16'h1234}, 29, q);
    repeat (6) @(posedge clock);
    chk({31'h0, serial_out_en}, 32'h0000_0000);
    master.sel(1'b0);
    master.sel(1'b1);
    master.shift({3'b100, 10'h300}, 13, q);
    master.sel(1'b0);
    master.sel(1'b1);
    master.shift({3'b101, 10'h005, 16'h1234}, 29, q);
    chk({30'h0, serial_out_en, serial_out}, 32'h0000_0002);
    repeat (30) @(posedge clock);
    chk({30'h0, serial_out_en, serial_out}, 32'h0000_0003);
    master.sel(1'b0);
    chk({31'h0, serial_out_en}, 32'h0000_0000);
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
  endtask : t_write
  // Reads back in both word widths; x8 address bit 0 picks the high byte.
  task automatic t_read();
    rd(11'h005, 10, 16, 16'h1234);
    width_select <= 1'b0;
    rd(11'h00B, 11, 8, 16'h0012);
    width_select <= 1'b1;
  endtask : t_read
  // Permit low blocks a write even when unlocked.
  task automatic t_permit();
    program_permit <= 1'b0;
    master.sel(1'b1);
    master.shift({3'b101, 10'h005, 16'hABCD}, 29, q);
    repeat (6) @(posedge clock);
    chk({31'h0, serial_out_en}, 32'h0000_0000);
    master.sel(1'b0);
    program_permit <= 1'b1;
    rd(11'h005, 10, 16, 16'h1234);
  endtask : t_permit
  // Erase deselected at once still completes; clocks while deselected do nothing.
  task automatic t_erase();
    master.sel(1'b1);
    master.shift({3'b111, 10'h005}, 13, q);
    master.sel(1'b0);
    master.shift(32'h0000_00FF, 8, q);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q & 32'h0000_0320, 32'h0000_0000);
    repeat (30) @(posedge clock);
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk(q, 32'h0000_0002);
    rd(11'h005, 10, 16, 16'hFFFF);
  endtask : t_erase
  // Software lock over the bus: lane 0 gates it, and a locked write is dropped.
  task automatic t_regs();
    avs_byteenable <= 4'hE;
    bus(1'b1, REG_CTRL, 32'hFFFF_FFFF, q);
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    avs_byteenable <= 4'h1;
    bus(1'b1, REG_CTRL, 32'h0000_0001, q);
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    master.sel(1'b1);
    master.shift({3'b101, 10'h005, 16'hABCD}, 29, q);
    repeat (6) @(posedge clock);
    chk({31'h0, serial_out_en}, 32'h0000_0000);
    master.sel(1'b0);
    bus(1'b1, REG_CTRL, 32'h0000_0000, q);
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, q);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q & 32'h0000_0013, 32'h0000_0002);
    avs_byteenable <= 4'hF;
  endtask : t_regs
  // Main sequence: reset for four cycles, then every scenario.
  initial begin
    nrst           = 1'b0;
    width_select   = 1'b1;
    program_permit = 1'b1;
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_write();
    t_read();
    t_permit();
    t_erase();
    t_regs();
    stop_test();
  end
endmodule : serial_eeprom_pin_control_tb

// >>> serial_master.sv
// Serial bus master model that drives the EEPROM select, clock and data pins.
// Assumes the device resynchronises every pin to the 40 MHz system clock.
`timescale 1ns/1ps
module serial_master (
  input  wire logic clock,
  output logic      select,
  output logic      serial_clk,
  output logic      serial_in,
  input  wire logic serial_out
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // Pins start low and the serial clock stands still between frames.
  initial begin
    select     = 1'b0;
    serial_clk = 1'b0;
    serial_in  = 1'b0;
  end
  // Changes select, then waits well over the 250 ns gap.
  task automatic sel(input logic v);
    select <= v;
    repeat (12) @(posedge clock);
  endtask : sel
  // Shifts n bits MSB first and captures serial_out after each rise.
  task automatic shift(input logic [31:0] b, input int n, output logic [31:0] q);
    q = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= b[i];
      repeat (6) @(posedge clock);
      serial_clk <= 1'b1;
      repeat (6) @(posedge clock);
      q = {q[30:0], serial_out};
      serial_clk <= 1'b0;
    end
  endtask : shift
endmodule : serial_master
